// file: dv/rsel_dpll_chk.sv
// Port-level assertions for the reference selection machine.
`timescale 1ns/100ps
`default_nettype none
module rsel_dpll_chk
  import rsel_pkg::*;
(
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  input wire logic                  managed_mode_i,
  input wire logic [RSEL_IDX_W-1:0] ref_sel_i,
  input wire logic [1:0]            dpll_state_o,
  input wire logic [RSEL_IDX_W-1:0] sel_ref_o,
  input wire logic                  holdover_o,
  input wire logic                  ref_switch_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence seq_pick;
    managed_mode_i && $changed(ref_sel_i) && ref_sel_i < RSEL_NUM_REF;
  endsequence
  sequence seq_park;
    seq_pick ##1 (managed_mode_i && $stable(ref_sel_i)) [*2];
  endsequence
  chk_hold_flag: assert property (holdover_o == (dpll_state_o == RSEL_STAT_HOLD))
    else $error("holdover flag and state differ");
  chk_pulse_one: assert property (ref_switch_o |=> !ref_switch_o)
    else $error("switch pulse too long");
  chk_sel_pulse: assert property (!$stable(sel_ref_o) |-> ref_switch_o)
    else $error("selection moved without pulse");
  chk_via_hold: assert property (ref_switch_o |-> $past(holdover_o))
    else $error("switch skipped holdover");
  chk_commit_state: assert property (ref_switch_o |-> dpll_state_o != RSEL_STAT_LOCK)
    else $error("locked at commit");
  chk_park_hold: assert property (seq_pick |-> ##1 holdover_o)
    else $error("no holdover after select");
  chk_park_commit: assert property (seq_park |=> sel_ref_o == $past(ref_sel_i))
    else $error("selection not committed");
  chk_managed_pick: assert property (ref_switch_o && $past(managed_mode_i, 2) |->
    sel_ref_o == $past(ref_sel_i, 2))
    else $error("managed switch to other ref");
endmodule : rsel_dpll_chk
bind rsel_dpll_fsm rsel_dpll_chk u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .managed_mode_i(managed_mode_i), .ref_sel_i(ref_sel_i),
  .dpll_state_o(dpll_state_o), .sel_ref_o(sel_ref_o), .holdover_o(holdover_o),
  .ref_switch_o(ref_switch_o));
`default_nettype wire

// file: dv/rsel_dpll_fsm_tb.sv
// Self-checking bench for the reference selection state machine.
`timescale 1ns/100ps
`default_nettype none
module rsel_dpll_fsm_tb
  import rsel_pkg::*;
;
  logic                                clk_i;
  logic                                rst_n_i;
  logic                                lock_i;
  logic                                mode;
  logic [RSEL_IDX_W-1:0]               sel;
  logic [RSEL_NUM_REF*RSEL_PRIO_W-1:0] prio;
  logic [RSEL_NUM_REF*RSEL_PRIO_W-1:0] pv;
  logic [RSEL_NUM_MON-1:0]             mask;
  logic [RSEL_NUM_REF-1:0]             fl [RSEL_NUM_MON];
  logic [RSEL_NUM_REF-1:0]             bad;
  logic [1:0]                          state;
  logic [RSEL_IDX_W-1:0]               ref_o;
  logic [RSEL_IDX_W-1:0]               cur;
  logic                                hold;
  logic                                sw;
  int                                  n_sw;
  int                                  m;
  int                                  errors;
  int                                  n_checks;
  rsel_host host (.clk_i(clk_i), .mode_o(mode), .sel_o(sel), .prio_o(pv), .mask_o(mask));
  rsel_dpll_fsm dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .managed_mode_i(mode), .ref_sel_i(sel),
    .ref_prio_i(pv), .signal_loss_fail_i(fl[RSEL_MON_LOSS]),
    .single_cycle_fail_i(fl[RSEL_MON_SCYC]), .coarse_freq_fail_i(fl[RSEL_MON_COARSE]),
    .precise_freq_fail_i(fl[RSEL_MON_FINE]), .guard_soak_trigger_i(fl[RSEL_MON_GUARD]),
    .switch_mask_i(mask), .holdover_mask_i(mask), .lock_detect_i(lock_i),
    .dpll_state_o(state), .sel_ref_o(ref_o), .holdover_o(hold), .ref_switch_o(sw));
  // Counts commit pulses so the bench can hold them against the number of switches.
  always @(posedge clk_i) begin
    if (sw === 1'b1) n_sw++;
  end
  function automatic logic [RSEL_IDX_W-1:0] best(input logic [RSEL_NUM_REF-1:0] b);
    logic [RSEL_PRIO_W-1:0] p;
    best = RSEL_SEL_RST;
    p = RSEL_PRIO_OFF;
    for (int r = 0; r < RSEL_NUM_REF; r++) begin
      if (!b[r] && prio[r*RSEL_PRIO_W+:RSEL_PRIO_W] < p) begin
        best = RSEL_IDX_W'(r);
        p = prio[r*RSEL_PRIO_W+:RSEL_PRIO_W];
      end
    end
  endfunction : best
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle
  task automatic fail(input int mon, input logic [RSEL_NUM_REF-1:0] v);
    @(posedge clk_i);
    foreach (fl[i]) fl[i] <= (i == mon) ? v : '0;
  endtask : fail
  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // The whole sequence needs under 150 cycles.
  initial begin
    repeat (1000) @(posedge clk_i);
    errors++;
    results();
  end
  initial begin
    void'($urandom(32'h23FE));
    errors = 0;
    n_checks = 0;
    n_sw = 0;
    rst_n_i = 1'b0;
    lock_i = 1'b0;
    foreach (fl[i]) fl[i] = '0;
    for (int r = 0; r < RSEL_NUM_REF; r++) prio[r*4+:4] = 4'($urandom_range(14, 0));
    host.setup(1'b0, RSEL_SEL_RST, 5'h1F, prio);
    settle(1);
    check("reset state", state, RSEL_STAT_HOLD);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    settle(4);
    bad = '0;
    cur = best(bad);
    check("first pick", ref_o, cur);
    check("first commit pulses", 8'(n_sw), 8'h01);
    @(posedge clk_i);
    lock_i <= 1'b1;
    settle(2);
    check("locked", state, RSEL_STAT_LOCK);
    $display("test start done");
    // Failed bits stay set, so earlier losers must never be picked again.
    for (int i = 0; i < 4; i++) begin
      m = $urandom_range(4, 0);
      bad[cur] = 1'b1;
      @(posedge clk_i);
      fl[m][cur] <= 1'b1;
      settle(4);
      cur = best(bad);
      check("switch target", ref_o, cur);
    end
    fail(m, '1);
    settle(3);
    check("all failed", hold, 1'b1);
    fail(0, '0);
    settle(3);
    check("hold released", hold, 1'b0);
    $display("test auto done");
    host.setup(1'b0, cur, 5'h00, prio);
    fail(m, RSEL_NUM_REF'(1) << cur);
    settle(4);
    check("unmasked", {hold, ref_o}, {1'b0, cur});
    fail(0, '0);
    cur = 4'((int'(cur) + $urandom_range(9, 1)) % RSEL_NUM_REF);
    host.setup(1'b1, cur, 5'h1F, prio);
    settle(4);
    check("managed sel", ref_o, cur);
    fail(m, RSEL_NUM_REF'(1) << cur);
    settle(3);
    check("managed hold", {hold, ref_o}, {1'b1, cur});
    fail(0, '0);
    settle(3);
    check("managed exit", hold, 1'b0);
    cur = 4'((int'(cur) + $urandom_range(9, 1)) % RSEL_NUM_REF);
    fail(m, RSEL_NUM_REF'(1) << cur);
    host.setup(1'b1, cur, 5'h1F, prio);
    settle(5);
    check("parked", hold, 1'b1);
    fail(0, '0);
    settle(3);
    check("valid again", {hold, ref_o}, {1'b0, cur});
    $display("test managed done");
    host.setup(1'b0, cur, 5'h1F, prio);
    settle(4);
    check("mode change", ref_o, cur);
    $display("test mode done");
    results();
  end
endmodule : rsel_dpll_fsm_tb
`default_nettype wire

// file: dv/rsel_host.sv
// Host processor model that programs mode, selection, priorities and masks.
`timescale 1ns/100ps
`default_nettype none
module rsel_host
  import rsel_pkg::*;
(
  input  wire logic                           clk_i,
  output logic                                mode_o,
  output logic [RSEL_IDX_W-1:0]               sel_o,
  output logic [RSEL_NUM_REF*RSEL_PRIO_W-1:0] prio_o,
  output logic [RSEL_NUM_MON-1:0]             mask_o
);
  initial begin
    mode_o = 1'b0;
    sel_o = RSEL_SEL_RST;
    prio_o = '0;
    mask_o = '0;
  end
  // Mode and selection are the host's own decisions; one mask value feeds both mask sets.
  task automatic setup(input logic mm, input logic [RSEL_IDX_W-1:0] s,
    input logic [RSEL_NUM_MON-1:0] m, input logic [RSEL_NUM_REF*RSEL_PRIO_W-1:0] p);
    @(posedge clk_i);
    mode_o <= mm;
    sel_o <= s;
    mask_o <= m;
    prio_o <= p;
  endtask : setup
endmodule : rsel_host
`default_nettype wire

// file: hdl/rsel_best_pick.sv
// Priority picker that finds the best available reference.
`timescale 1ns/100ps
`default_nettype none

module rsel_best_pick
  import rsel_pkg::*;
(
  input  wire logic [RSEL_NUM_REF-1:0]             avail_i,
  input  wire logic [RSEL_NUM_REF*RSEL_PRIO_W-1:0] prio_i,
  output logic                                     found_o,
  output logic [RSEL_IDX_W-1:0]                    idx_o
);

  logic [RSEL_PRIO_W-1:0] best_prio;
  logic [RSEL_PRIO_W-1:0] cur_prio;

  // Lower priority value wins; on a tie the lower index wins.
  always_comb begin
    found_o   = 1'b0;
    idx_o     = RSEL_SEL_RST;
    best_prio = RSEL_PRIO_OFF;
    cur_prio  = RSEL_PRIO_OFF;
    for (int r = 0; r < RSEL_NUM_REF; r++) begin
      cur_prio = prio_i[r*RSEL_PRIO_W +: RSEL_PRIO_W];
      if (avail_i[r] && (cur_prio != RSEL_PRIO_OFF) &&
          (!found_o || (cur_prio < best_prio))) begin
        found_o   = 1'b1;
        idx_o     = RSEL_IDX_W'(r);
        best_prio = cur_prio;
      end
    end
  end

endmodule : rsel_best_pick

`default_nettype wire

// file: hdl/rsel_dpll_fsm.sv
// Reference selection and holdover state machine for one DPLL.
`timescale 1ns/100ps
`default_nettype none

module rsel_dpll_fsm
  import rsel_pkg::*;
(
  input  wire logic                                 clk_i,
  input  wire logic                                 rst_n_i,
  input  wire logic                                 managed_mode_i,
  input  wire logic [RSEL_IDX_W-1:0]                ref_sel_i,
  input  wire logic [RSEL_NUM_REF*RSEL_PRIO_W-1:0]  ref_prio_i,
  input  wire logic [RSEL_NUM_REF-1:0]              signal_loss_fail_i,
  input  wire logic [RSEL_NUM_REF-1:0]              single_cycle_fail_i,
  input  wire logic [RSEL_NUM_REF-1:0]              coarse_freq_fail_i,
  input  wire logic [RSEL_NUM_REF-1:0]              precise_freq_fail_i,
  input  wire logic [RSEL_NUM_REF-1:0]              guard_soak_trigger_i,
  input  wire logic [RSEL_NUM_MON-1:0]              switch_mask_i,
  input  wire logic [RSEL_NUM_MON-1:0]              holdover_mask_i,
  input  wire logic                                 lock_detect_i,
  output logic      [1:0]                           dpll_state_o,
  output logic      [RSEL_IDX_W-1:0]                sel_ref_o,
  output logic                                      holdover_o,
  output logic                                      ref_switch_o
);

  // True when any monitor flags a failure whose mask bit is set.
  function automatic logic masked_hit(input logic [RSEL_NUM_MON-1:0] fails,
                                      input logic [RSEL_NUM_MON-1:0] mask);
    masked_hit = |(fails & mask);
  endfunction : masked_hit

  // Per-reference flag lookup; an index past the last reference reads as failed.
  function automatic logic ref_flag(input logic [RSEL_NUM_REF-1:0] vec,
                                    input logic [RSEL_IDX_W-1:0]   idx);
    if (idx < RSEL_IDX_W'(RSEL_NUM_REF)) begin
      ref_flag = vec[idx];
    end else begin
      ref_flag = 1'b1;
    end
  endfunction : ref_flag

  function automatic logic [1:0] stat_code(input rsel_state_type st);
    unique case (st)
      RSEL_ST_LOCK: stat_code = RSEL_STAT_LOCK;
      RSEL_ST_HOLD: stat_code = RSEL_STAT_HOLD;
      default:      stat_code = RSEL_STAT_ACQ;
    endcase
  endfunction : stat_code

  // Per-reference masked failure decode, redone every cycle from the live levels.
  logic [RSEL_NUM_REF-1:0] sw_fail;
  logic [RSEL_NUM_REF-1:0] ho_fail;
  logic [RSEL_NUM_REF-1:0] avail;

  genvar g;
  generate
    for (g = 0; g < RSEL_NUM_REF; g++) begin : g_ref
      logic [RSEL_NUM_MON-1:0] mon;
      assign mon[RSEL_MON_LOSS]   = signal_loss_fail_i[g];
      assign mon[RSEL_MON_SCYC]   = single_cycle_fail_i[g];
      assign mon[RSEL_MON_COARSE] = coarse_freq_fail_i[g];
      assign mon[RSEL_MON_FINE]   = precise_freq_fail_i[g];
      assign mon[RSEL_MON_GUARD]  = guard_soak_trigger_i[g];
      assign sw_fail[g] = masked_hit(mon, switch_mask_i);
      assign ho_fail[g] = masked_hit(mon, holdover_mask_i);
      // Unmasked failures leave a reference available, so the loop keeps trying it.
      assign avail[g]   = ~sw_fail[g] & ~ho_fail[g];
    end
  endgenerate

  // State registers.
  rsel_state_type          state_reg;
  rsel_state_type          state_next;
  logic [RSEL_IDX_W-1:0]   sel_reg;
  logic [RSEL_IDX_W-1:0]   sel_next;
  logic                    sel_valid_reg;
  logic                    sel_valid_next;
  logic                    pend_reg;
  logic                    pend_next;
  logic [RSEL_IDX_W-1:0]   tgt_reg;
  logic [RSEL_IDX_W-1:0]   tgt_next;
  logic [1:0]              stat_reg;
  logic [1:0]              stat_next;
  logic                    hold_reg;
  logic                    hold_next;
  logic                    pulse_reg;
  logic                    pulse_next;

  // Candidate set excludes the reference in use, so a failing current one is never reselected.
  logic [RSEL_NUM_REF-1:0] cand;
  logic                    best_found;
  logic [RSEL_IDX_W-1:0]   best_idx;

  always_comb begin
    cand = avail;
    if (sel_valid_reg && (sel_reg < RSEL_IDX_W'(RSEL_NUM_REF))) begin
      cand[sel_reg] = 1'b0;
    end
  end

  rsel_best_pick u_pick (
    .avail_i (cand),
    .prio_i  (ref_prio_i),
    .found_o (best_found),
    .idx_o   (best_idx)
  );

  logic                  cur_sw;
  logic                  cur_ho;
  logic                  want_switch;
  logic [RSEL_IDX_W-1:0] want_tgt;

  always_comb begin
    // Before any reference is committed the DPLL is treated as failed, so it holds.
    cur_sw = sel_valid_reg & ref_flag(sw_fail, sel_reg);
    cur_ho = ~sel_valid_reg | ref_flag(ho_fail, sel_reg);
    if (managed_mode_i) begin
      // Only the selection bits move the reference; failures never do.
      // While parked, compare against the pending target so the last selection wins.
      want_switch = ~sel_valid_reg |
                    (ref_sel_i != (pend_reg ? tgt_reg : sel_reg));
      want_tgt    = ref_sel_i;
    end else begin
      // A switch away from the current reference needs its own masked failure,
      // which is why leaving managed mode never moves the reference by itself.
      want_switch = best_found & (~sel_valid_reg | cur_sw);
      want_tgt    = best_idx;
    end
  end

  always_comb begin
    state_next     = state_reg;
    sel_next       = sel_reg;
    sel_valid_next = sel_valid_reg;
    pend_next      = pend_reg;
    tgt_next       = tgt_reg;
    pulse_next     = 1'b0;
    if (want_switch && !(state_reg == RSEL_ST_HOLD && pend_reg && want_tgt == tgt_reg)) begin
      // Park in holdover first; a target that moves meanwhile just restarts the park.
      state_next = RSEL_ST_HOLD;
      pend_next  = 1'b1;
      tgt_next   = want_tgt;
    end else if (state_reg == RSEL_ST_HOLD && pend_reg) begin
      // Commit: the index moves in the same cycle as the state leaves holdover.
      sel_next       = tgt_reg;
      sel_valid_next = 1'b1;
      pend_next      = 1'b0;
      pulse_next     = 1'b1;
      // An invalid or failed new reference keeps the DPLL in holdover.
      state_next     = ref_flag(ho_fail, tgt_reg) ? RSEL_ST_HOLD : RSEL_ST_ACQ;
    end else begin
      unique case (state_reg)
        RSEL_ST_ACQ: begin
          if (cur_ho) begin
            state_next = RSEL_ST_HOLD;
          end else if (lock_detect_i) begin
            state_next = RSEL_ST_LOCK;
          end
        end
        RSEL_ST_LOCK: begin
          if (cur_ho) begin
            state_next = RSEL_ST_HOLD;
          end else if (!lock_detect_i) begin
            state_next = RSEL_ST_ACQ;
          end
        end
        RSEL_ST_HOLD: begin
          if (!cur_ho) begin
            state_next = RSEL_ST_ACQ;
          end
        end
        default: begin
          state_next = RSEL_ST_HOLD;
        end
      endcase
    end
    stat_next = stat_code(state_next);
    hold_next = (state_next == RSEL_ST_HOLD);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg     <= RSEL_ST_HOLD;
      sel_reg       <= RSEL_SEL_RST;
      sel_valid_reg <= 1'b0;
      pend_reg      <= 1'b0;
      tgt_reg       <= RSEL_SEL_RST;
      stat_reg      <= RSEL_STAT_HOLD;
      hold_reg      <= 1'b1;
      pulse_reg     <= 1'b0;
    end else begin
      state_reg     <= state_next;
      sel_reg       <= sel_next;
      sel_valid_reg <= sel_valid_next;
      pend_reg      <= pend_next;
      tgt_reg       <= tgt_next;
      stat_reg      <= stat_next;
      hold_reg      <= hold_next;
      pulse_reg     <= pulse_next;
    end
  end

  // One instance serves one DPLL; several DPLLs use several independent instances.
  assign dpll_state_o = stat_reg;
  assign sel_ref_o    = sel_reg;
  assign holdover_o   = hold_reg;
  assign ref_switch_o = pulse_reg;

endmodule : rsel_dpll_fsm

`default_nettype wire

// file: hdl/rsel_pkg.sv
// Constants, state codes and monitor layout for the reference selection state machine.
package rsel_pkg;

  localparam int RSEL_NUM_REF = 10;
  localparam int RSEL_IDX_W   = 4;
  localparam int RSEL_PRIO_W  = 4;
  localparam int RSEL_NUM_MON = 5;

  // Monitor bit positions inside a per-reference failure vector and inside each mask.
  localparam int RSEL_MON_LOSS   = 0;
  localparam int RSEL_MON_SCYC   = 1;
  localparam int RSEL_MON_COARSE = 2;
  localparam int RSEL_MON_FINE   = 3;
  localparam int RSEL_MON_GUARD  = 4;

  // A priority of this value removes the reference from automatic selection.
  localparam logic [RSEL_PRIO_W-1:0] RSEL_PRIO_OFF = 4'hF;

  localparam logic [RSEL_IDX_W-1:0] RSEL_SEL_RST = 4'h0;

  // Reported DPLL state codes.
  localparam logic [1:0] RSEL_STAT_ACQ  = 2'h0;
  localparam logic [1:0] RSEL_STAT_LOCK = 2'h1;
  localparam logic [1:0] RSEL_STAT_HOLD = 2'h2;

  typedef enum logic [2:0] {
    RSEL_ST_ACQ  = 3'b001,
    RSEL_ST_LOCK = 3'b010,
    RSEL_ST_HOLD = 3'b100
  } rsel_state_type;

endpackage : rsel_pkg
